// ---- hdl/tac_pkg.sv ----
// package of constants for the type a timer control block
package tac_pkg;
   // register byte addresses
   localparam logic [11:0] TAC_CTRL_ADDR = 12'h000;
   localparam logic [11:0] TAC_COUNT_ADDR = 12'h004;
   localparam logic [11:0] TAC_PERIOD_ADDR = 12'h008;
   // control field positions
   localparam int TAC_ON_BIT = 15;
   localparam int TAC_IDLE_STOP_BIT = 13;
   localparam int TAC_WBLOCK_BIT = 12;
   localparam int TAC_WPEND_BIT = 11;
   localparam int TAC_GATE_BIT = 7;
   localparam int TAC_PS_LO = 4;
   localparam int TAC_SYNC_BIT = 2;
   localparam int TAC_CS_BIT = 1;
   // writable control bits: 15,13,12,7,5,4,2,1
   localparam logic [31:0] TAC_CTRL_WMASK = 32'h0000_b0b6;
   localparam logic [31:0] TAC_CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] TAC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] TAC_PERIOD_RESET = 16'hffff;
   // prescale codes and divide counts
   localparam logic [1:0] TAC_PS_1 = 2'h0;
   localparam logic [1:0] TAC_PS_8 = 2'h1;
   localparam logic [1:0] TAC_PS_64 = 2'h2;
   localparam logic [1:0] TAC_PS_256 = 2'h3;
   localparam logic [7:0] TAC_DIV_8_LAST = 8'h07;
   localparam logic [7:0] TAC_DIV_64_LAST = 8'h3f;
   localparam logic [7:0] TAC_DIV_256_LAST = 8'hff;
   // cycles an asynchronous count write stays pending after its first pending cycle
   localparam logic [1:0] TAC_ASYNC_WR_CYCLES = 2'h3;
   localparam logic [1:0] TAC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TAC_RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/tac_prescaler.sv ----
// input prescaler: pulses once per 1, 8, 64 or 256 input ticks
`timescale 1ns/100ps
module tac_prescaler
   import tac_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // control
   input wire logic clear,
   input wire logic tick,
   input wire logic [1:0] sel,
   // result
   output logic tick_out
);
   typedef struct packed {
      logic [7:0] cnt;
      logic out;
   } tac_ps_state_t;
   tac_ps_state_t st, next_st;
   logic [7:0] last;

   always_comb begin
      next_st = st;
      next_st.out = 1'b0;
      case (sel)
         TAC_PS_8: last = TAC_DIV_8_LAST;
         TAC_PS_64: last = TAC_DIV_64_LAST;
         TAC_PS_256: last = TAC_DIV_256_LAST;
         default: last = 8'h00;
      endcase
      if (clear) begin
         next_st.cnt = 8'h00;
      end else if (tick) begin
         if (st.cnt >= last) begin
            next_st.cnt = 8'h00;
            next_st.out = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick_out = st.out;
endmodule

// ---- hdl/tac_timer.sv ----
// type a timer with control register, count and period on axi4-lite
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module tac_timer
   import tac_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // chip state and pins
   input wire logic idle_mode,
   input wire logic ext_clk_pin,
   input wire logic gate_pin,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer event
   output logic period_match
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [15:0] count;
      logic [15:0] period;
      logic [15:0] wr_value;
      logic [1:0] wr_wait;
      logic wr_pend;
      logic [2:0] ext_sync;
      logic [1:0] gate_sync;
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic match;
   } tac_state_t;
   tac_state_t st, next_st;

   logic ps_tick;
   logic ps_clear;
   logic src_tick;
   logic run;
   logic async_mode;
   logic [31:0] wmask;
   logic [31:0] ctrl_read;

   // external clock edge after the two-flop synchroniser; the async path is
   // modelled in the bus domain too, since the block has one clock only
   assign async_mode = st.ctrl[TAC_CS_BIT] & ~st.ctrl[TAC_SYNC_BIT];
   assign ps_clear = ~st.ctrl[TAC_ON_BIT];

   always_comb begin
      src_tick = 1'b1;
      if (st.ctrl[TAC_CS_BIT]) begin
         src_tick = st.ext_sync[1] & ~st.ext_sync[2];
      end else if (st.ctrl[TAC_GATE_BIT]) begin
         src_tick = st.gate_sync[1];
      end
      // gate enable is not looked at while the external source is picked
      run = st.ctrl[TAC_ON_BIT] & ~(st.ctrl[TAC_IDLE_STOP_BIT] & idle_mode);
   end

   tac_prescaler u_ps (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clear(ps_clear),
      .tick(src_tick & run),
      .sel(st.ctrl[TAC_PS_LO+1:TAC_PS_LO]),
      .tick_out(ps_tick)
   );

   always_comb begin
      ctrl_read = st.ctrl & TAC_CTRL_WMASK;
      ctrl_read[TAC_WPEND_BIT] = st.wr_pend & async_mode;
      for (int i = 0; i < 32; i++) begin
         wmask[i] = st.w_strb[i/8];
      end
   end

   always_comb begin
      next_st = st;
      next_st.ext_sync = {st.ext_sync[1:0], ext_clk_pin};
      next_st.gate_sync = {st.gate_sync[0], gate_pin};
      next_st.match = 1'b0;
      next_st.awready = 1'b0;
      next_st.wready = 1'b0;
      next_st.arready = 1'b0;

      // counting
      if (ps_tick && run) begin
         if (st.count == st.period) begin
            next_st.count = TAC_COUNT_RESET;
            next_st.match = 1'b1;
         end else begin
            next_st.count = st.count + 16'h0001;
         end
      end

      // pending asynchronous count write lands after a fixed delay
      if (st.wr_pend) begin
         if (st.wr_wait == 2'h0) begin
            next_st.wr_pend = 1'b0;
            next_st.count = st.wr_value;
         end else begin
            next_st.wr_wait = st.wr_wait - 2'h1;
         end
      end

      // write channels, taken in either order
      if (s_axi_awvalid && !st.aw_got && !st.awready) begin
         next_st.awready = 1'b1;
         next_st.aw_got = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_got && !st.wready) begin
         next_st.wready = 1'b1;
         next_st.w_got = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = TAC_RESP_OKAY;
         case (st.aw_addr)
            TAC_CTRL_ADDR: begin
               next_st.ctrl = ((st.ctrl & ~(wmask & TAC_CTRL_WMASK)) |
                  (st.w_data & wmask & TAC_CTRL_WMASK));
            end
            TAC_COUNT_ADDR: begin
               if (async_mode) begin
                  if (!(st.wr_pend && st.ctrl[TAC_WBLOCK_BIT])) begin
                     next_st.wr_pend = 1'b1;
                     next_st.wr_wait = TAC_ASYNC_WR_CYCLES;
                     next_st.wr_value = st.w_data[15:0];
                  end
               end else begin
                  next_st.count = st.w_data[15:0];
               end
            end
            TAC_PERIOD_ADDR: begin
               next_st.period = st.w_data[15:0];
            end
            default: begin
               next_st.bresp = TAC_RESP_SLVERR;
            end
         endcase
      end else if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      // read channel
      if (s_axi_arvalid && !st.rvalid && !st.arready) begin
         next_st.arready = 1'b1;
         next_st.rvalid = 1'b1;
         next_st.rresp = TAC_RESP_OKAY;
         case (s_axi_araddr)
            TAC_CTRL_ADDR: next_st.rdata = ctrl_read;
            TAC_COUNT_ADDR: next_st.rdata = {16'h0000, st.count};
            TAC_PERIOD_ADDR: next_st.rdata = {16'h0000, st.period};
            default: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = TAC_RESP_SLVERR;
            end
         endcase
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
         st.ctrl <= TAC_CTRL_RESET;
         st.count <= TAC_COUNT_RESET;
         st.period <= TAC_PERIOD_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign period_match = st.match;
endmodule

// ---- sim/tac_timer_asserts.sv ----
// concurrent checks on the bus side of the timer control block
`timescale 1ns/100ps
module tac_timer_asserts
   import tac_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // write side
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // data is judged at the accept edge, where rdata is already loaded
   wire rd_ctrl = s_axi_arvalid && s_axi_arready && s_axi_araddr == TAC_CTRL_ADDR;
   AST_CTRL_UNUSED_ZERO: assert property (rd_ctrl |->
      (s_axi_rdata & ~(TAC_CTRL_WMASK | 32'h0000_0800)) == 32'h0) else $error("unused bits set");
   AST_SYNC_NO_PEND: assert property (rd_ctrl && !(s_axi_rdata[1] && !s_axi_rdata[2]) |->
      !s_axi_rdata[11]) else $error("pending flag set in sync mode");
   AST_RD_LATENCY: assert property (s_axi_arready |-> s_axi_rvalid) else $error("late read data");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_WR_RESP: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
      else $error("late write response");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready stuck");
   AST_BAD_WR: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > TAC_PERIOD_ADDR
      |=> s_axi_bvalid && s_axi_bresp == TAC_RESP_SLVERR) else $error("unmapped write okay");
   AST_BAD_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > TAC_PERIOD_ADDR
      |-> s_axi_rresp == TAC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule
bind tac_timer tac_timer_asserts u_chk (.*);

// ---- sim/testbench.sv ----
// self-checking bench for the timer control block
`timescale 1ns/100ps
module testbench
   import tac_pkg::*;
;
   logic mclk = 1'b0, sys_rst = 1'b1, idle_mode = 1'b0, ext_clk_pin = 1'b0, gate_pin = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, a, b, c;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, period_match;
   int miscompares = 0, samples_checked = 0, lag = 0, cyc = 0, last = 0;
   int div[4] = '{1, 8, 64, 256};
   bit skip = 1'b0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int pq[$];
   tac_timer dut (.*);
   always #4 mclk = ~mclk;
   // external clock of eight bus cycles, edges away from the sampling edge
   always #32 ext_clk_pin = ~ext_clk_pin;
   task check(string what, logic [33:0] exp, logic [33:0] got);
      samples_checked++;
      if (exp !== got) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wr(logic [11:0] ad, logic [31:0] d, logic [1:0] rs = TAC_RESP_OKAY);
      bq.push_back(rs);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      repeat (lag) @(posedge mclk);
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task rd(logic [11:0] ad, logic [31:0] d, logic [1:0] rs = TAC_RESP_OKAY);
      rq.push_back({rs, d});
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (lag) @(posedge mclk);
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // restart from zero count, expect pulses n cycles apart, or none when n is 0
   task run(logic [31:0] cv, int n);
      wr(TAC_CTRL_ADDR, 32'h0);
      @(posedge mclk);
      wr(TAC_COUNT_ADDR, 32'h0);
      skip = (n > 0);
      if (n > 0) pq.push_back(n);
      wr(TAC_CTRL_ADDR, cv);
      // a stopped timer must still hold the zero it was loaded with
      if (n == 0) begin
         repeat (300) @(posedge mclk);
         rd(TAC_COUNT_ADDR, 32'h0);
      end else begin
         wait (pq.size() == 0);
      end
      wr(TAC_CTRL_ADDR, 32'h0);
      @(posedge mclk);
   endtask
   always @(posedge mclk) begin
      if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
      if (s_axi_rvalid && s_axi_rready) check("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   // first pulse after a restart carries start-up latency, so it only marks time
   always @(posedge mclk) begin
      cyc++;
      if (period_match) begin
         if (skip) skip = 1'b0;
         else check("interval", 34'(pq.size() ? pq.pop_front() : 0), 34'(cyc - last));
         last = cyc;
      end
   end
   initial begin
      repeat (40000) @(posedge mclk);
      miscompares++;
      close_out;
   end
   initial begin
      void'($urandom(33));
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      lag = $urandom % 3;
      rd(TAC_CTRL_ADDR, TAC_CTRL_RESET);
      rd(TAC_PERIOD_ADDR, 32'(TAC_PERIOD_RESET));
      r = $urandom;
      wr(TAC_CTRL_ADDR, r);
      rd(TAC_CTRL_ADDR, r & TAC_CTRL_WMASK);
      wr(12'h00c, $urandom, TAC_RESP_SLVERR);
      rd(12'h00c, 32'h0, TAC_RESP_SLVERR);
      wr(TAC_PERIOD_ADDR, 32'h7);
      rd(TAC_PERIOD_ADDR, 32'h7);
      lag = 0;
      for (int k = 0; k < 3; k++) begin
         c = (k == 2) ? 32'h6 : 32'h2 | 32'(k) << 12;
         a = $urandom;
         b = $urandom;
         wr(TAC_CTRL_ADDR, c);
         wr(TAC_COUNT_ADDR, a);
         wr(TAC_COUNT_ADDR, b);
         // with block set the dropped write restarts nothing, so the first one has landed
         rd(TAC_CTRL_ADDR, c | (k == 0 ? 32'h800 : 32'h0));
         repeat (12) @(posedge mclk);
         rd(TAC_CTRL_ADDR, c);
         rd(TAC_COUNT_ADDR, {16'h0, k == 1 ? a[15:0] : b[15:0]});
      end
      idle_mode <= 1'b1;
      for (int i = 0; i < 4; i++) run(32'h8000 | 32'(i) << 4, 8 * div[i]);
      run(32'ha000, 0);
      idle_mode <= 1'b0;
      run(32'h0006, 0);
      run(32'h8080, 0);
      gate_pin <= 1'b1;
      run(32'h8080, 8);
      gate_pin <= 1'b0;
      run(32'h8086, 64);
      run(32'h8082, 64);
      close_out;
   end
endmodule
